// ==== verilog/ssc_port.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ssc_params.svh"

module ssc_port #(
   parameter int PUP_CYCLES = `SSC_TPUP_NS / `SSC_CLK_NS,
   parameter int NUM_REGS = `SSC_REG_CNT
) (
   input wire logic MCLK,
   input wire logic RST,
   input wire logic SERIAL_CLK,
   input wire logic SERIAL_DATA_IN,
   input wire logic SERIAL_ENABLE_N,
   input wire logic POWER_DOWN_N_PIN,
   input wire logic IF_PLL_CLK,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire ssc_pkg::ssc_paddr_t PADDR,
   input wire ssc_pkg::ssc_word32_t PWDATA,
   output ssc_pkg::ssc_word32_t PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output logic RF_HIGH_BAND_PLL_ACTIVE,
   output logic RF_LOW_BAND_PLL_ACTIVE,
   output logic RF_PLL_ON,
   output logic IF_PLL_ON,
   output logic RF_TUNE_START,
   output logic IF_TUNE_START,
   output logic RF_PLL_READY,
   output logic IF_PLL_READY,
   output logic INTERMEDIATE_FREQ_OUTPUT
);
   import ssc_pkg::*;

   // Tune counter wide enough for the longest settle
   localparam int TW = $clog2(PUP_CYCLES + 1);
   localparam logic [TW-1:0] TUNE_LOAD = TW'(PUP_CYCLES);

   // Three-stage pin pipeline
   logic [`SSC_PIN_W-1:0] s0_r;
   logic [`SSC_PIN_W-1:0] s1_r;
   logic [`SSC_PIN_W-1:0] s2_r;
   // Filtered pin levels and their next values
   logic [`SSC_PIN_W-1:0] filt_r;
   logic [`SSC_PIN_W-1:0] filt_nxt;
   wire [`SSC_PIN_W-1:0] pins_in;

   // Serial shift register
   logic [`SSC_WORD_W-1:0] shift_r;
   // Internal data registers
   ssc_data_t regs_r [NUM_REGS];

   // Active RF loop
   ssc_band_t band_r;
   // Per-loop state: index 0 RF, index 1 IF
   logic [1:0] on_r;
   logic [1:0] on_nxt;
   logic [1:0] start_w;
   logic [1:0] freq_chg;
   logic [1:0] tune_r;
   logic [1:0] ready_r;
   logic [TW-1:0] tcnt_r [2];

   // IF output divider
   logic [2:0] div_r;
   logic [2:0] div_nxt;
   logic intermediate_freq_output_r;

   // Software view
   logic [3:0] sel_r;
   logic [`SSC_CNT_W-1:0] ok_cnt_r;
   logic [`SSC_CNT_W-1:0] bad_cnt_r;
   ssc_word32_t prdata_r;
   logic pready_r;
   logic pslverr_r;

   assign pins_in = {IF_PLL_CLK, POWER_DOWN_N_PIN, SERIAL_ENABLE_N,
                     SERIAL_DATA_IN, SERIAL_CLK};

   // Synchroniser chain; stage 0 feeds stage 1 only
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         s0_r <= `SSC_PIN_RST;
         s1_r <= `SSC_PIN_RST;
         s2_r <= `SSC_PIN_RST;
         filt_r <= `SSC_PIN_RST;
      end else begin
         s0_r <= pins_in;
         s1_r <= s0_r;
         s2_r <= s1_r;
         filt_r <= filt_nxt;
      end
   end

   // Accept a level once stages two and three agree
   assign filt_nxt = (~(s1_r ^ s2_r) & s2_r) | ((s1_r ^ s2_r) & filt_r);

   // Edge and level decode of the filtered pins
   wire sclk_rise = filt_nxt[`SSC_PIN_SCLK] & ~filt_r[`SSC_PIN_SCLK];
   wire sdat_lvl = filt_nxt[`SSC_PIN_SDAT];
   wire serial_enable_n_lvl = filt_nxt[`SSC_PIN_SERIAL_ENABLE_N];
   wire serial_enable_n_rise = serial_enable_n_lvl & ~filt_r[`SSC_PIN_SERIAL_ENABLE_N];
   wire pin_lvl = filt_nxt[`SSC_PIN_PWDN];
   wire ifck_rise = filt_nxt[`SSC_PIN_IFCK] & ~filt_r[`SSC_PIN_IFCK];

   // Shift only while the enable is low
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         shift_r <= '0;
      end else if (!serial_enable_n_lvl && sclk_rise) begin
         // Oldest bits fall off the top, keeping the last word
         shift_r <= {shift_r[`SSC_WORD_W-2:0], sdat_lvl};
      end
   end

   // Address sits in the last four bits shifted, data ahead of it
   wire ssc_addr_t wr_addr = shift_r[`SSC_ADDR_LSB +: `SSC_ADDR_W];
   wire ssc_data_t wr_data = shift_r[`SSC_DATA_LSB +: `SSC_DATA_W];
   // Word only lands when the address names a real register
   wire addr_ok = int'(wr_addr) < NUM_REGS;
   wire wr_ok = serial_enable_n_rise && addr_ok;
   wire wr_bad = serial_enable_n_rise && !addr_ok;

   // Register decode of the landing word
   wire wr_hi = wr_ok && (wr_addr == `SSC_REG_N_HI || wr_addr == `SSC_REG_R_HI);
   wire wr_lo = wr_ok && (wr_addr == `SSC_REG_N_LO || wr_addr == `SSC_REG_R_LO);
   wire wr_iff = wr_ok && (wr_addr == `SSC_REG_N_IF || wr_addr == `SSC_REG_R_IF);
   wire wr_pwr = wr_ok && (wr_addr == `SSC_REG_PWR);
   wire ssc_data_t pwr_now = wr_pwr ? wr_data : regs_r[`SSC_REG_PWR];

   // One storage process per register entry
   genvar g;
   generate
      for (g = 0; g < NUM_REGS; g++) begin : g_reg
         // Power register comes up with both loops enabled
         localparam ssc_data_t RV = (g == int'(`SSC_REG_PWR)) ?
                                    `SSC_REG2_RST : `SSC_REG_RST;
         always_ff @(posedge MCLK or posedge RST) begin
            if (RST) begin
               regs_r[g] <= RV;
            end else if (wr_ok && wr_addr == 4'(g)) begin
               regs_r[g] <= wr_data;
            end
         end
      end
   endgenerate

   // Last written RF divider picks the active loop
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         band_r <= SSC_BAND_HIGH;
      end else if (wr_hi) begin
         band_r <= SSC_BAND_HIGH;
      end else if (wr_lo) begin
         band_r <= SSC_BAND_LOW;
      end
   end

   // Loop power: pin and software bit must both allow it
   // Acting on the agreeing stages keeps shutdown within four clocks
   assign on_nxt[0] = pin_lvl & pwr_now[`SSC_PWR_RF_BIT];
   assign on_nxt[1] = pin_lvl & pwr_now[`SSC_PWR_IF_BIT];
   // Either RF band rewritten counts as a new RF frequency
   assign freq_chg[0] = wr_hi | wr_lo;
   assign freq_chg[1] = wr_iff;

   // Per-loop tuning sequencer
   generate
      for (g = 0; g < 2; g++) begin : g_pll
         // Start on power-up, or on a retune while already up
         assign start_w[g] = on_nxt[g] & (~on_r[g] | freq_chg[g]);
         always_ff @(posedge MCLK or posedge RST) begin
            if (RST) begin
               on_r[g] <= 1'b0;
               tune_r[g] <= 1'b0;
               ready_r[g] <= 1'b0;
               tcnt_r[g] <= '0;
            end else begin
               on_r[g] <= on_nxt[g];
               tune_r[g] <= start_w[g];
               if (!on_nxt[g]) begin
                  // Shutdown abandons any tuning in progress
                  tcnt_r[g] <= '0;
                  ready_r[g] <= 1'b0;
               end else if (start_w[g]) begin
                  tcnt_r[g] <= TUNE_LOAD;
                  ready_r[g] <= 1'b0;
               end else if (tcnt_r[g] != '0) begin
                  tcnt_r[g] <= tcnt_r[g] - 1'b1;
                  ready_r[g] <= (tcnt_r[g] == TW'(1));
               end
            end
         end
      end
   endgenerate

   // IF divider counts sampled oscillator edges
   // Sampling limits the usable oscillator rate to well below MCLK/2
   wire [`SSC_IFDIV_W-1:0] div_sel = regs_r[`SSC_REG_CFG][`SSC_IFDIV_LSB +: `SSC_IFDIV_W];
   assign div_nxt = ifck_rise ? div_r + 3'h1 : div_r;
   wire div_bit = (div_sel == 2'h0) ? filt_nxt[`SSC_PIN_IFCK] :
                  div_nxt[div_sel - 2'h1];

   // Divider state and gated output
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         div_r <= '0;
         intermediate_freq_output_r <= 1'b0;
      end else begin
         div_r <= div_nxt;
         // Output held low while the IF loop is off
         intermediate_freq_output_r <= div_bit & on_nxt[1];
      end
   end

   // Latched and discarded word tallies, wrapping
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         ok_cnt_r <= '0;
         bad_cnt_r <= '0;
      end else begin
         if (wr_ok) begin
            ok_cnt_r <= ok_cnt_r + 1'b1;
         end
         if (wr_bad) begin
            bad_cnt_r <= bad_cnt_r + 1'b1;
         end
      end
   end

   // APB phases
   wire apb_setup = PSEL & ~PENABLE & ~pready_r;
   wire apb_done = PSEL & PENABLE & pready_r;

   // Address decode
   wire hit_status = PADDR == `SSC_APB_STATUS;
   wire hit_sel = PADDR == `SSC_APB_SEL;
   wire hit_data = PADDR == `SSC_APB_DATA;
   wire hit_count = PADDR == `SSC_APB_COUNT;
   wire apb_hit = hit_status | hit_sel | hit_data | hit_count;

   // Readback of the selected internal register
   wire sel_ok = int'(sel_r) < NUM_REGS;
   wire ssc_data_t sel_data = sel_ok ? regs_r[sel_r] : '0;
   wire ssc_word32_t status_w = {24'h000000, filt_r[`SSC_PIN_SERIAL_ENABLE_N],
                                 filt_r[`SSC_PIN_PWDN], ready_r, on_r,
                                 band_r};
   wire ssc_word32_t rd_mux = hit_status ? status_w :
                              hit_sel ? {28'h0000000, sel_r} :
                              hit_data ? {14'h0000, sel_data} :
                              hit_count ? {bad_cnt_r, ok_cnt_r} : '0;

   // One wait-free access: data and ready leave flops
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         pready_r <= 1'b0;
         prdata_r <= '0;
         pslverr_r <= 1'b0;
         sel_r <= '0;
      end else begin
         pready_r <= apb_setup;
         if (apb_setup) begin
            prdata_r <= PWRITE ? '0 : rd_mux;
            // Unmapped address answers with an error
            pslverr_r <= ~apb_hit;
         end else if (apb_done) begin
            prdata_r <= '0;
            pslverr_r <= 1'b0;
         end
         // Only the select word is writable
         if (apb_done && PWRITE && hit_sel) begin
            sel_r <= PWDATA[3:0];
         end
      end
   end

   // Outputs straight from flops
   assign PRDATA = prdata_r;
   assign PREADY = pready_r;
   assign PSLVERR = pslverr_r;
   assign RF_HIGH_BAND_PLL_ACTIVE = band_r[0];
   assign RF_LOW_BAND_PLL_ACTIVE = band_r[1];
   assign RF_PLL_ON = on_r[0];
   assign IF_PLL_ON = on_r[1];
   assign RF_TUNE_START = tune_r[0];
   assign IF_TUNE_START = tune_r[1];
   assign RF_PLL_READY = ready_r[0];
   assign IF_PLL_READY = ready_r[1];
   assign INTERMEDIATE_FREQ_OUTPUT = intermediate_freq_output_r;

endmodule
`default_nettype wire

// ==== verilog/ssc_params.svh ====
`ifndef SSC_PARAMS_SVH
`define SSC_PARAMS_SVH
// Serial word layout
`define SSC_WORD_W 22
`define SSC_DATA_W 18
`define SSC_ADDR_W 4
`define SSC_ADDR_LSB 0
`define SSC_DATA_LSB 4
// Implemented internal registers 0..8
`define SSC_REG_CNT 9
`define SSC_REG_CFG 4'h0
`define SSC_REG_PWR 4'h2
`define SSC_REG_N_HI 4'h3
`define SSC_REG_N_LO 4'h4
`define SSC_REG_N_IF 4'h5
`define SSC_REG_R_HI 4'h6
`define SSC_REG_R_LO 4'h7
`define SSC_REG_R_IF 4'h8
// Fields
`define SSC_PWR_RF_BIT 0
`define SSC_PWR_IF_BIT 1
`define SSC_IFDIV_LSB 0
`define SSC_IFDIV_W 2
`define SSC_REG_RST 18'h00000
`define SSC_REG2_RST 18'h00003
// Timing
`define SSC_CLK_NS 25
`define SSC_TPUP_NS 200000
// Pin synchroniser: sclk, serial_data_in, serial_enable_n_n, pwdn_n, if clock
`define SSC_PIN_W 5
`define SSC_PIN_RST 5'h04
`define SSC_PIN_SCLK 0
`define SSC_PIN_SDAT 1
`define SSC_PIN_SERIAL_ENABLE_N 2
`define SSC_PIN_PWDN 3
`define SSC_PIN_IFCK 4
// APB map
`define SSC_APB_STATUS 12'h000
`define SSC_APB_SEL 12'h004
`define SSC_APB_DATA 12'h008
`define SSC_APB_COUNT 12'h00C
`define SSC_CNT_W 16
`endif

// ==== verilog/ssc_pkg.sv ====
package ssc_pkg;
   // One-hot choice of the active RF loop
   typedef enum logic [1:0] {
      SSC_BAND_HIGH = 2'b01,
      SSC_BAND_LOW = 2'b10
   } ssc_band_t;
   typedef logic [17:0] ssc_data_t;
   typedef logic [3:0] ssc_addr_t;
   typedef logic [11:0] ssc_paddr_t;
   typedef logic [31:0] ssc_word32_t;
endpackage

// ==== dv/ssc_port_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
// Pin-level checks on the port block, bound from the bench
module ssc_port_properties #(
   parameter int PUP_CYCLES = 20
) (
   input wire logic MCLK,
   input wire logic RST,
   input wire logic POWER_DOWN_N_PIN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic RF_HIGH_BAND_PLL_ACTIVE,
   input wire logic RF_LOW_BAND_PLL_ACTIVE,
   input wire logic RF_PLL_ON,
   input wire logic IF_PLL_ON,
   input wire logic RF_TUNE_START,
   input wire logic RF_PLL_READY,
   input wire logic INTERMEDIATE_FREQ_OUTPUT
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);
   a_band_one_hot: assert property (RF_HIGH_BAND_PLL_ACTIVE != RF_LOW_BAND_PLL_ACTIVE)
      else $error("band select not one-hot");
   a_tune_single: assert property (RF_TUNE_START |=> !RF_TUNE_START)
      else $error("tune pulse too long");
   a_rise_tunes: assert property ($rose(RF_PLL_ON) |-> RF_TUNE_START)
      else $error("power-up without tune");
   a_pin_down: assert property ($fell(POWER_DOWN_N_PIN) |-> ##[1:4] (!RF_PLL_ON && !IF_PLL_ON))
      else $error("slow power-down");
   a_ready_delay: assert property ($rose(RF_PLL_READY) |-> $past(RF_TUNE_START, PUP_CYCLES))
      else $error("ready at wrong time");
   a_if_quiet: assert property (!IF_PLL_ON [*2] |-> !INTERMEDIATE_FREQ_OUTPUT)
      else $error("IF output while off");
   a_pready_zero: assert property ($rose(PENABLE) && PSEL |-> PREADY)
      else $error("access not answered");
   a_pready_once: assert property (PREADY |=> !PREADY)
      else $error("ready held");
   a_err_ready: assert property (PSLVERR |-> PREADY)
      else $error("error without ready");
endmodule
`default_nettype wire

// ==== dv/ssc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Serial host; clock idles low outside frames
module ssc_host_model (
   input wire logic MCLK,
   output var logic SERIAL_CLK,
   output var logic SERIAL_DATA_IN,
   output var logic SERIAL_ENABLE_N
);
   initial begin
      SERIAL_CLK = 1'b0;
      SERIAL_DATA_IN = 1'b0;
      SERIAL_ENABLE_N = 1'b1;
   end
   // Low n bits of w go out, MSB first, 8 clocks (200 ns) a bit
   // Every pin moves just after a system clock edge
   task automatic send(input logic [25:0] w, input int n);
      @(posedge MCLK);
      SERIAL_ENABLE_N <= 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         SERIAL_DATA_IN <= w[i];
         repeat (4) @(posedge MCLK);
         SERIAL_CLK <= 1'b1;
         repeat (4) @(posedge MCLK);
         SERIAL_CLK <= 1'b0;
      end
      // Enable rises well after the last clock edge
      repeat (4) @(posedge MCLK);
      SERIAL_ENABLE_N <= 1'b1;
      // Released line no longer shows the last bit
      SERIAL_DATA_IN <= ~SERIAL_DATA_IN;
   endtask
   // Clock and data toggling while disabled
   task automatic wiggle(input int n);
      @(posedge MCLK);
      for (int i = 0; i < n; i++) begin
         SERIAL_DATA_IN <= ~SERIAL_DATA_IN;
         repeat (4) @(posedge MCLK);
         SERIAL_CLK <= 1'b1;
         repeat (4) @(posedge MCLK);
         SERIAL_CLK <= 1'b0;
      end
      // Keep the last fall clear of a following enable edge
      repeat (4) @(posedge MCLK);
   endtask
endmodule
`default_nettype wire

// ==== dv/ssc_port_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ssc_params.svh"
module ssc_port_bench;
   import ssc_pkg::*;
   logic mclk, rst, pwdn_n, if_clk, psel, penable, pwrite;
   ssc_paddr_t paddr;
   ssc_word32_t pwdata, prdata, q;
   wire logic sclk, sdat, serial_enable_n_n;
   logic pready, pslverr, hi, lo, ron, ion, rts, its, rrdy, irdy, ifo, e, ifo_q;
   int err_count, comparisons, rf_t, if_t, ifc, ifr, ofr, okn, badn;
   ssc_addr_t al [4] = '{4'h7, 4'h3, 4'h4, 4'h6};
   initial begin
      {rst, pwdn_n, if_clk, psel, penable, pwrite, ifo_q} = 7'h63;
      {paddr, pwdata} = '0;
      {err_count, comparisons, rf_t, if_t, ifc, ifr, ofr, okn, badn} = '0;
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   ssc_host_model u_host (.MCLK(mclk), .SERIAL_CLK(sclk), .SERIAL_DATA_IN(sdat),
      .SERIAL_ENABLE_N(serial_enable_n_n));
   ssc_port #(.PUP_CYCLES(20)) u_dut (.MCLK(mclk), .RST(rst), .SERIAL_CLK(sclk),
      .SERIAL_DATA_IN(sdat), .SERIAL_ENABLE_N(serial_enable_n_n), .POWER_DOWN_N_PIN(pwdn_n),
      .IF_PLL_CLK(if_clk), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .RF_HIGH_BAND_PLL_ACTIVE(hi), .RF_LOW_BAND_PLL_ACTIVE(lo), .RF_PLL_ON(ron),
      .IF_PLL_ON(ion), .RF_TUNE_START(rts), .IF_TUNE_START(its), .RF_PLL_READY(rrdy),
      .IF_PLL_READY(irdy), .INTERMEDIATE_FREQ_OUTPUT(ifo));
   // Slow IF stand-in, period 20 cycles, plus edge tallies
   always @(posedge mclk) begin
      ifc++;
      if (ifc % 10 == 0) begin
         ifr += !if_clk;
         if_clk <= ~if_clk;
      end
      rf_t += (rts === 1'b1);
      if_t += (its === 1'b1);
      ofr += (ifo === 1'b1 && ifo_q === 1'b0);
      ifo_q = ifo;
   end
   task automatic chk(input string n, input ssc_word32_t x, input ssc_word32_t g);
      comparisons++;
      if (g !== x) begin
         err_count++;
         $display("CHECK FAILED %s exp %h got %h", n, x, g);
      end
   endtask
   // One APB transfer; waits for pready, only the watchdog ends a hang
   task automatic apb(input logic w, input ssc_paddr_t a, input ssc_word32_t d);
      @(posedge mclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic rreg(input ssc_addr_t i);
      apb(1'b1, `SSC_APB_SEL, {28'h0000000, i});
      apb(1'b0, `SSC_APB_DATA, 32'h00000000);
   endtask
   // Serial write of n bits, four junk bits ahead of the word
   task automatic ser(input ssc_addr_t a, input ssc_data_t d, input int n);
      u_host.send({4'hA, d, a}, n);
      if (a < 9) okn++;
      else badn++;
      repeat (6) @(posedge mclk);
   endtask
   task automatic t_count();
      apb(1'b0, `SSC_APB_COUNT, 32'h00000000);
      chk("count", {badn[15:0], okn[15:0]}, q);
   endtask
   task automatic t_band();
      foreach (al[k]) begin
         ser(al[k], 18'h2A5A5 + al[k], 22);
         chk("hi", al[k] == 3 || al[k] == 6, hi);
         chk("lo", al[k] == 4 || al[k] == 7, lo);
         // One RF tune from the power-up after reset, then one per write
         chk("rftune", k + 2, rf_t);
         rreg(al[k]);
         chk("data", 18'h2A5A5 + al[k], q);
      end
   endtask
   task automatic t_odd();
      ser(4'h5, 18'h01234, 26);
      rreg(4'h5);
      chk("long", 32'h00001234, q);
      // Power-up tune after reset plus this frequency change
      chk("iftune", 2, if_t);
      ser(4'h9, 18'h3FFFF, 22);
      rreg(4'h6);
      chk("bad", 32'h0002A5AB, q);
      u_host.wiggle(5);
      // Empty frame presents the untouched unmapped word again, and it is discarded again
      ser(4'h9, 18'h0, 0);
      chk("hold", 1, hi);
      rreg(4'h6);
      chk("frozen", 32'h0002A5AB, q);
      rreg(4'h5);
      chk("unshifted", 32'h00001234, q);
      t_count();
      apb(1'b0, 12'h010, 32'h00000000);
      chk("slverr", 1, e);
   endtask
   task automatic t_power();
      ser(4'h2, 18'h0, 22);
      chk("swoff", 0, {ron, ion});
      ser(4'h2, 18'h3, 22);
      repeat (25) @(posedge mclk);
      chk("swon", 32'h0000000F, {ron, ion, rrdy, irdy});
      pwdn_n <= 1'b0;
      repeat (5) @(posedge mclk);
      chk("pinoff", 0, {ron, ion});
      pwdn_n <= 1'b1;
      repeat (30) @(posedge mclk);
      chk("pinon", 32'h0000000F, {ron, ion, rrdy, irdy});
      // Reset power-up, IF divider write, software and pin power-ups
      chk("retunes", 32'h00000004, if_t);
   endtask
   task automatic t_ifdiv();
      int a0, b0, d;
      for (int k = 0; k < 4; k++) begin
         ser(4'h0, 18'(k), 22);
         a0 = ifr;
         b0 = ofr;
         repeat (1280) @(posedge mclk);
         d = (ofr - b0) * (1 << k) - (ifr - a0);
         chk("ifdiv", 1, d <= (1 << k) && d >= -(1 << k));
      end
   endtask
   task automatic summarize();
      if (err_count == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      repeat (30) @(posedge mclk);
      apb(1'b0, `SSC_APB_STATUS, 32'h00000000);
      chk("status", 32'h000000FD, q);
      t_count();
      t_band();
      t_odd();
      t_power();
      t_ifdiv();
      summarize();
   end
   initial begin
      #1000000;
      err_count++;
      summarize();
   end
endmodule
bind ssc_port ssc_port_properties #(.PUP_CYCLES(PUP_CYCLES)) u_props (.MCLK, .RST,
   .POWER_DOWN_N_PIN, .PSEL, .PENABLE, .PREADY, .PSLVERR, .RF_HIGH_BAND_PLL_ACTIVE,
   .RF_LOW_BAND_PLL_ACTIVE, .RF_PLL_ON, .IF_PLL_ON, .RF_TUNE_START, .RF_PLL_READY,
   .INTERMEDIATE_FREQ_OUTPUT);
`default_nettype wire
